// *** sdio_host_model.sv ***
// host controller model driving the command pins of the drive
`timescale 1ns/100ps
module sdio_host_model (
  // clock and wanted pins {second, first, clamp, servo}
  input wire logic       sys_clk,
  input wire logic [3:0] pin_cmd,
  input wire logic [3:0] lag,
  // command pins, high means closed to common
  output logic           servo_enable_input,
  output logic           speed_clamp_input,
  output logic           speed_select_first,
  output logic           speed_select_second
);
  logic [3:0] pins = 4'h0;
  logic [3:0] wait_cnt = 4'h0;
  assign {speed_select_second, speed_select_first, speed_clamp_input, servo_enable_input} = pins;
  // contacts settle a random number of cycles after the host decides
  always @(posedge sys_clk) begin
    wait_cnt <= (pin_cmd == pins) ? 4'h0 : wait_cnt + 4'h1;
    if (pin_cmd != pins && wait_cnt >= lag) pins <= pin_cmd;
  end
endmodule // sdio_host_model

// *** sdio_io_select.sv ***
// servo drive i/o select: warning output, encoder pulse out, speed select
//
// Our own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/100ps
module sdio_io_select
  import sdio_pkg::*;
#(
  parameter int SPEED_W = SDIO_SPEED_W
) (
  // clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  // wishbone classic slave
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [SDIO_ADDR_W-1:0] wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [SDIO_DATA_W-1:0] wb_dat_i,
  output logic      [SDIO_DATA_W-1:0] wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        irq,
  // command pins from the host, high means closed to common
  input  wire logic                   servo_enable_input,
  input  wire logic                   speed_clamp_input,
  input  wire logic                   speed_select_first,
  input  wire logic                   speed_select_second,
  // drive internals, same clock
  input  wire logic                   torque_limited,
  input  wire logic [SPEED_W-1:0]     motor_speed,
  input  wire logic                   regen_warning,
  input  wire logic                   overload_warning,
  input  wire logic                   fan_warning,
  input  wire logic [SPEED_W-1:0]     regen_load,
  input  wire logic [SPEED_W-1:0]     regen_detect_level,
  input  wire logic [SPEED_W-1:0]     effective_torque,
  input  wire logic [SPEED_W-1:0]     overload_warn_level,
  input  wire logic                   enc_div_a,
  input  wire logic                   enc_div_b,
  input  wire logic                   enc_div_z,
  // drive command outputs
  output logic                        drive_enable,
  output logic                        motor_run,
  output logic      [SPEED_W-1:0]     speed_command,
  output logic                        warning_out,
  // encoder pulse outputs
  output logic                        enc_out_a_pos,
  output logic                        enc_out_a_neg,
  output logic                        enc_out_b_pos,
  output logic                        enc_out_b_neg,
  output logic                        enc_out_z_pos,
  output logic                        enc_out_z_neg,
  output logic                        index_open_collector_out,
  output logic                        index_open_collector_oe
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  logic servo_on, clamp_closed, sel_first, sel_second;
  logic servo_chg, clamp_chg;

  sdio_sync_filter #(.RESET_LEVEL(1'b0)) u_sync_servo (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin_in  (servo_enable_input),
    .level   (servo_on),
    .changed (servo_chg)
  );
  sdio_sync_filter #(.RESET_LEVEL(1'b0)) u_sync_clamp (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin_in  (speed_clamp_input),
    .level   (clamp_closed),
    .changed (clamp_chg)
  );
  sdio_sync_filter #(.RESET_LEVEL(1'b0)) u_sync_sel1 (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin_in  (speed_select_first),
    .level   (sel_first),
    .changed ()
  );
  sdio_sync_filter #(.RESET_LEVEL(1'b0)) u_sync_sel2 (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .pin_in  (speed_select_second),
    .level   (sel_second),
    .changed ()
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0]            warn_sel;
  logic                  pulse_inv;
  logic [3:0]            ctrl_mode;
  logic [SPEED_W-1:0]    zero_speed_threshold;
  logic [SPEED_W-1:0]    speed_preset_one;
  logic [SPEED_W-1:0]    speed_preset_two;
  logic [SPEED_W-1:0]    speed_preset_three;
  logic [SPEED_W-1:0]    speed_preset_four;
  logic [SDIO_IRQ_W-1:0] irq_status;
  logic [SDIO_IRQ_W-1:0] irq_mask;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire        bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire        bus_wr    = bus_req && wb_we_i;
  wire        lane0     = wb_sel_i[0];
  wire        lane1     = wb_sel_i[1];
  wire        hit_cfg   = (wb_adr_i == SDIO_OFS_CONFIG);
  wire        hit_zspd  = (wb_adr_i == SDIO_OFS_ZSPEED);
  wire        hit_p1    = (wb_adr_i == SDIO_OFS_PRESET1);
  wire        hit_p2    = (wb_adr_i == SDIO_OFS_PRESET2);
  wire        hit_p3    = (wb_adr_i == SDIO_OFS_PRESET3);
  wire        hit_p4    = (wb_adr_i == SDIO_OFS_PRESET4);
  wire        hit_stat  = (wb_adr_i == SDIO_OFS_STATUS);
  wire        hit_ist   = (wb_adr_i == SDIO_OFS_IRQ_ST);
  wire        hit_imsk  = (wb_adr_i == SDIO_OFS_IRQ_MSK);
  wire        hit_spd   = (wb_adr_i == SDIO_OFS_SPEED);
  wire [15:0] wr_half   = wb_dat_i[15:0];

  // a 16-bit field merges the written byte lanes with the old value
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [15:0] val,
                                          input logic        l0,
                                          input logic        l1);
    merge16 = {l1 ? val[15:8] : old[15:8], l0 ? val[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // speed selection and drive state
  // ----------------------------------------------------------------
  sdio_drive_type       drive_state;
  sdio_drive_type       next_drive_state;
  logic [1:0]           speed_index;
  logic [1:0]           last_index;
  logic [SPEED_W-1:0]   selected_speed;
  wire int_vel_mode = (ctrl_mode == SDIO_MODE_INT_VEL);
  // first select is the low bit: open/open 1, closed/open 2, open/closed 3
  assign speed_index = {sel_second, sel_first};
  assign selected_speed = (speed_index == 2'h0) ? speed_preset_one :
                          (speed_index == 2'h1) ? speed_preset_two :
                          (speed_index == 2'h2) ? speed_preset_three :
                                                  speed_preset_four;
  // servo enable gates the drive state, not the warning or encoder outputs; the drive runs only in velocity mode, and there the clamp gates it
  always_comb begin
    next_drive_state = drive_state;
    case (drive_state)
      SDIO_ST_OFF: begin
        if (servo_on) begin
          next_drive_state = SDIO_ST_HOLD;
        end
      end
      SDIO_ST_HOLD: begin
        if (!servo_on) begin
          next_drive_state = SDIO_ST_OFF;
        end else if (int_vel_mode && clamp_closed) begin
          next_drive_state = SDIO_ST_GO;
        end
      end
      SDIO_ST_GO: begin
        if (!servo_on) begin
          next_drive_state = SDIO_ST_OFF;
        end else if (!int_vel_mode || !clamp_closed) begin
          next_drive_state = SDIO_ST_HOLD;
        end
      end
      default: begin
        next_drive_state = SDIO_ST_OFF;
      end
    endcase
  end

  wire running = (drive_state == SDIO_ST_GO);

  // ----------------------------------------------------------------
  // warning source selection
  // ----------------------------------------------------------------
  // widened products so the 85 percent compare never overflows
  logic [23:0] regen_scaled;
  logic [23:0] regen_limit;
  logic        next_warning;

  assign regen_scaled = 24'(regen_load) * 24'(SDIO_FULL_PCT);
  assign regen_limit  = 24'(regen_detect_level) * 24'(SDIO_REGEN_PCT);
  wire cond_torque = torque_limited;
  wire cond_zspeed = (motor_speed < zero_speed_threshold);
  wire cond_any    = regen_warning || overload_warning || fan_warning;
  wire cond_regen  = (regen_scaled > regen_limit);
  wire cond_ovld   = (effective_torque > overload_warn_level);
  wire cond_fan    = fan_warning;
  assign next_warning = (warn_sel == SDIO_WSEL_TORQUE) ? cond_torque :
                        (warn_sel == SDIO_WSEL_ZSPEED) ? cond_zspeed :
                        (warn_sel == SDIO_WSEL_ANY)    ? cond_any :
                        (warn_sel == SDIO_WSEL_REGEN)  ? cond_regen :
                        (warn_sel == SDIO_WSEL_OVLD)   ? cond_ovld :
                        (warn_sel == SDIO_WSEL_FAN)    ? cond_fan :
                                                         1'b0;

  // ----------------------------------------------------------------
  // interrupt events
  // ----------------------------------------------------------------
  wire                  warn_rise = next_warning && !warning_out;
  wire                  idx_chg   = (speed_index != last_index);
  wire [SDIO_IRQ_W-1:0] irq_event = {idx_chg, clamp_chg, servo_chg, warn_rise};
  wire [SDIO_IRQ_W-1:0] irq_clear = (bus_wr && hit_ist && lane0) ?
                                    wb_dat_i[SDIO_IRQ_W-1:0] :
                                    {SDIO_IRQ_W{1'b0}};
  // set wins over a clear landing in the same cycle
  wire [SDIO_IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_event;

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  wire [31:0] rd_cfg  = {20'h00000, ctrl_mode, 3'h0, pulse_inv, 1'b0, warn_sel};
  wire [31:0] rd_stat = {22'h000000, speed_index, 2'h0, running, warning_out,
                         sel_second, sel_first, clamp_closed, servo_on};
  wire [31:0] rd_data =
    hit_cfg  ? rd_cfg :
    hit_zspd ? 32'(zero_speed_threshold) :
    hit_p1   ? 32'(speed_preset_one) :
    hit_p2   ? 32'(speed_preset_two) :
    hit_p3   ? 32'(speed_preset_three) :
    hit_p4   ? 32'(speed_preset_four) :
    hit_stat ? rd_stat :
    hit_ist  ? 32'(irq_status) :
    hit_imsk ? 32'(irq_mask) :
    hit_spd  ? 32'(speed_command) :
               32'h00000000;

  // ----------------------------------------------------------------
  // bus slave: one wait state, unmapped reads zero, writes dropped
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_data : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      warn_sel  <= SDIO_WARN_RESET;
      pulse_inv <= 1'b0;
      ctrl_mode <= SDIO_MODE_RESET;
    end else if (bus_wr && hit_cfg) begin
      if (lane0) begin
        warn_sel  <= wb_dat_i[SDIO_CFG_WARN_LSB +: 3];
        pulse_inv <= wb_dat_i[SDIO_CFG_INV_BIT];
      end
      if (lane1) begin
        ctrl_mode <= wb_dat_i[SDIO_CFG_MODE_LSB +: 4];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      zero_speed_threshold <= SDIO_ZSPEED_RESET;
      speed_preset_one     <= SDIO_PRESET_RESET;
      speed_preset_two     <= SDIO_PRESET_RESET;
      speed_preset_three   <= SDIO_PRESET_RESET;
      speed_preset_four    <= SDIO_PRESET_RESET;
    end else if (bus_wr) begin
      if (hit_zspd) zero_speed_threshold <= merge16(zero_speed_threshold, wr_half, lane0, lane1);
      if (hit_p1) speed_preset_one <= merge16(speed_preset_one, wr_half, lane0, lane1);
      if (hit_p2) speed_preset_two <= merge16(speed_preset_two, wr_half, lane0, lane1);
      if (hit_p3) speed_preset_three <= merge16(speed_preset_three, wr_half, lane0, lane1);
      if (hit_p4) speed_preset_four <= merge16(speed_preset_four, wr_half, lane0, lane1);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_status <= {SDIO_IRQ_W{1'b0}};
      irq_mask   <= {SDIO_IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      if (bus_wr && hit_imsk && lane0) irq_mask <= wb_dat_i[SDIO_IRQ_W-1:0];
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // drive outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      drive_state   <= SDIO_ST_OFF;
      last_index    <= 2'h0;
      drive_enable  <= 1'b0;
      motor_run     <= 1'b0;
      speed_command <= {SPEED_W{1'b0}};
      warning_out   <= 1'b0;
    end else begin
      drive_state   <= next_drive_state;
      last_index    <= speed_index;
      drive_enable  <= servo_on;
      motor_run     <= (next_drive_state == SDIO_ST_GO);
      // an open clamp forces zero speed rather than coasting on a preset
      speed_command <= (next_drive_state == SDIO_ST_GO) ?
                       selected_speed : {SPEED_W{1'b0}};
      warning_out   <= next_warning;
    end
  end

  // ----------------------------------------------------------------
  // encoder pulse outputs
  // ----------------------------------------------------------------
  // inversion flips phase b only, which swaps which phase leads
  wire b_phase = enc_div_b ^ pulse_inv;

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      enc_out_a_pos            <= 1'b0;
      enc_out_a_neg            <= 1'b1;
      enc_out_b_pos            <= 1'b0;
      enc_out_b_neg            <= 1'b1;
      enc_out_z_pos            <= 1'b0;
      enc_out_z_neg            <= 1'b1;
      index_open_collector_out <= 1'b0;
      index_open_collector_oe  <= 1'b0;
    end else begin
      enc_out_a_pos            <= enc_div_a;
      enc_out_a_neg            <= !enc_div_a;
      enc_out_b_pos            <= b_phase;
      enc_out_b_neg            <= !b_phase;
      enc_out_z_pos            <= enc_div_z;
      enc_out_z_neg            <= !enc_div_z;
      // transistor pulls low only, so the level is always zero
      index_open_collector_out <= 1'b0;
      index_open_collector_oe  <= enc_div_z;
    end
  end

endmodule // sdio_io_select

// *** sdio_io_select_monitor.sv ***
// assertion checker for the servo drive i/o select block
`timescale 1ns/100ps
module sdio_io_select_monitor
  import sdio_pkg::*;
#(
  parameter int SPEED_W = SDIO_SPEED_W
) (
  // clock, reset and bus
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic                   wb_cyc_i,
  input wire logic                   wb_stb_i,
  input wire logic [SDIO_DATA_W-1:0] wb_dat_o,
  input wire logic                   wb_ack_o,
  // pins and drive
  input wire logic                   servo_enable_input,
  input wire logic                   speed_clamp_input,
  input wire logic                   enc_div_a,
  input wire logic                   drive_enable,
  input wire logic                   motor_run,
  input wire logic [SPEED_W-1:0]     speed_command,
  // encoder outputs
  input wire logic                   enc_out_a_pos,
  input wire logic                   enc_out_a_neg,
  input wire logic                   enc_out_b_pos,
  input wire logic                   enc_out_b_neg,
  input wire logic                   enc_out_z_pos,
  input wire logic                   enc_out_z_neg,
  input wire logic                   index_open_collector_oe
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  sequence bus_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence run_off; !motor_run [*2]; endsequence
  ack_answer_a: assert property (bus_req |=> wb_ack_o) else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == '0) else $error("read data outside ack");
  enc_follow_a: assert property ($past(resetn) |-> enc_out_a_pos == $past(enc_div_a))
    else $error("phase a not one cycle behind");
  enc_pair_a: assert property (enc_out_a_neg != enc_out_a_pos && enc_out_b_neg != enc_out_b_pos
    && enc_out_z_neg != enc_out_z_pos) else $error("pair not complementary");
  index_oe_a: assert property (index_open_collector_oe == enc_out_z_pos) else $error("index oc wrong");
  servo_sync_a: assert property ($changed(drive_enable) |-> $past(servo_enable_input, 2) == drive_enable)
    else $error("servo pin not synchronised");
  run_cause_a: assert property ($rose(motor_run) |-> drive_enable && $past(speed_clamp_input, 2))
    else $error("run without servo and clamp");
  speed_idle_a: assert property (run_off |-> speed_command == '0) else $error("speed while stopped");
endmodule // sdio_io_select_monitor

bind sdio_io_select sdio_io_select_monitor #(.SPEED_W(SPEED_W)) u_monitor (.sys_clk, .resetn, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .servo_enable_input, .speed_clamp_input, .enc_div_a, .drive_enable,
  .motor_run, .speed_command, .enc_out_a_pos, .enc_out_a_neg, .enc_out_b_pos, .enc_out_b_neg,
  .enc_out_z_pos, .enc_out_z_neg, .index_open_collector_oe);

// *** sdio_pkg.sv ***
// constants and register map of the servo drive i/o select block
package sdio_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int          SDIO_ADDR_W      = 8;
  localparam int          SDIO_DATA_W      = 32;
  localparam int          SDIO_SPEED_W     = 16;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0]  SDIO_OFS_CONFIG  = 8'h00;
  localparam logic [7:0]  SDIO_OFS_ZSPEED  = 8'h04;
  localparam logic [7:0]  SDIO_OFS_PRESET1 = 8'h08;
  localparam logic [7:0]  SDIO_OFS_PRESET2 = 8'h0c;
  localparam logic [7:0]  SDIO_OFS_PRESET3 = 8'h10;
  localparam logic [7:0]  SDIO_OFS_PRESET4 = 8'h14;
  localparam logic [7:0]  SDIO_OFS_STATUS  = 8'h18;
  localparam logic [7:0]  SDIO_OFS_IRQ_ST  = 8'h1c;
  localparam logic [7:0]  SDIO_OFS_IRQ_MSK = 8'h20;
  localparam logic [7:0]  SDIO_OFS_SPEED   = 8'h24;

  // ----------------------------------------------------------------
  // config register fields and reset values
  // ----------------------------------------------------------------
  localparam int          SDIO_CFG_WARN_LSB = 0;
  localparam int          SDIO_CFG_INV_BIT  = 4;
  localparam int          SDIO_CFG_MODE_LSB = 8;
  localparam logic [2:0]  SDIO_WARN_RESET   = 3'h0;
  localparam logic [3:0]  SDIO_MODE_RESET   = 4'h2;
  localparam logic [3:0]  SDIO_MODE_INT_VEL = 4'h1;
  localparam logic [15:0] SDIO_ZSPEED_RESET = 16'h0000;
  localparam logic [15:0] SDIO_PRESET_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // warning source codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  SDIO_WSEL_TORQUE  = 3'h0;
  localparam logic [2:0]  SDIO_WSEL_ZSPEED  = 3'h1;
  localparam logic [2:0]  SDIO_WSEL_ANY     = 3'h2;
  localparam logic [2:0]  SDIO_WSEL_REGEN   = 3'h3;
  localparam logic [2:0]  SDIO_WSEL_OVLD    = 3'h4;
  localparam logic [2:0]  SDIO_WSEL_DISPLAY = 3'h5;
  localparam logic [2:0]  SDIO_WSEL_FAN     = 3'h6;

  // regenerative warning level, percent of detection level
  localparam logic [7:0]  SDIO_REGEN_PCT    = 8'h55;
  localparam logic [7:0]  SDIO_FULL_PCT     = 8'h64;

  // ----------------------------------------------------------------
  // status and interrupt bit positions
  // ----------------------------------------------------------------
  localparam int          SDIO_ST_SERVO     = 0;
  localparam int          SDIO_ST_CLAMP     = 1;
  localparam int          SDIO_ST_SEL1      = 2;
  localparam int          SDIO_ST_SEL2      = 3;
  localparam int          SDIO_ST_WARN      = 4;
  localparam int          SDIO_ST_RUN       = 5;
  localparam int          SDIO_ST_IDX_LSB   = 8;
  localparam int          SDIO_IRQ_W        = 4;
  localparam int          SDIO_IRQ_WARN     = 0;
  localparam int          SDIO_IRQ_SERVO    = 1;
  localparam int          SDIO_IRQ_CLAMP    = 2;
  localparam int          SDIO_IRQ_SPEED    = 3;

  // ----------------------------------------------------------------
  // drive state, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SDIO_ST_OFF  = 3'h1,
    SDIO_ST_HOLD = 3'h2,
    SDIO_ST_GO   = 3'h4
  } sdio_drive_type;

endpackage

// *** sdio_sync_filter.sv ***
// three-stage synchroniser with agreement filter for one pin input
`timescale 1ns/100ps
module sdio_sync_filter #(
  parameter logic RESET_LEVEL = 1'b0
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic resetn,
  // pin side
  input  wire logic pin_in,
  // clocked side
  output logic      level,
  output logic      changed
);

  logic [2:0] stage;
  wire        agree = (stage[1] == stage[2]);

  // stage[0] feeds only stage[1]; level moves once stages 1 and 2 agree
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stage   <= {3{RESET_LEVEL}};
      level   <= RESET_LEVEL;
      changed <= 1'b0;
    end else begin
      stage   <= {stage[1:0], pin_in};
      if (agree) begin
        level <= stage[2];
      end
      changed <= agree && (stage[2] != level);
    end
  end

endmodule // sdio_sync_filter

// *** tb_top.sv ***
// self-checking testbench for the servo drive i/o select block
`timescale 1ns/100ps
module tb_top;
  import sdio_pkg::*;
  logic sys_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, run;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, pin_cmd = 4'h0, lag = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_q[$];
  logic torque_limited = 1'b0, regen_warning = 1'b0, overload_warning = 1'b0, fan_warning = 1'b0;
  logic [15:0] motor_speed = 16'h0, regen_load = 16'h0, regen_detect_level = 16'h03e8, effective_torque = 16'h0;
  logic [15:0] overload_warn_level = 16'h0200, speed_command, pre[4];
  logic [2:0] enc = 3'h0, s;
  logic wb_ack_o, irq, drive_enable, motor_run, warning_out, servo_enable_input, speed_clamp_input;
  logic speed_select_first, speed_select_second, enc_out_a_pos, enc_out_a_neg, enc_out_b_pos, enc_out_b_neg;
  logic enc_out_z_pos, enc_out_z_neg, index_open_collector_out, index_open_collector_oe;
  int seed = 74791, miscompares = 0, comparisons = 0;
  sdio_io_select dut (.*, .enc_div_a(enc[0]), .enc_div_b(enc[1]), .enc_div_z(enc[2]));
  sdio_host_model host (.*);
  always #2.5 sys_clk = ~sys_clk;
  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    if (miscompares == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // reads are noted here and judged when ack shows
  always @(posedge sys_clk) if (wb_ack_o === 1'b1 && !wb_we_i) chk(wb_dat_o, exp_q.pop_front());
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [31:0] exp);
    if (!we) exp_q.push_back(exp);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, adr, dat, 4'hf};
    do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge sys_clk);
  endtask
  function automatic logic warn_exp(input logic [2:0] sel);
    case (sel)
      3'h0: return torque_limited;
      3'h1: return motor_speed < 16'h0100;
      3'h2: return regen_warning | overload_warning | fan_warning;
      3'h3: return 32'(regen_load) * 100 > 32'(regen_detect_level) * 85;
      3'h4: return effective_torque > overload_warn_level;
      3'h6: return fan_warning;
      default: return 1'b0;
    endcase
  endfunction
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, SDIO_OFS_CONFIG, 32'h0, 32'h0000_0200);
    wb(1'b1, 8'h3c, 32'hffff_ffff, 32'h0);
    wb(1'b0, 8'h3c, 32'h0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      pre[i] = 16'($random(seed));
      wb(1'b1, SDIO_OFS_PRESET1 + 8'(4 * i), {16'h0, pre[i]}, 32'h0);
    end
    wb(1'b1, SDIO_OFS_CONFIG, 32'h0000_0100, 32'h0);
    for (int i = 0; i < 8; i++) begin
      run = (i < 4);
      lag <= 4'($random(seed));
      pin_cmd <= {2'(i), run, 1'b1};
      repeat (30) @(posedge sys_clk);
      chk(motor_run, run);
      chk(speed_command, run ? pre[2'(i)] : 16'h0);
      wb(1'b0, SDIO_OFS_SPEED, 32'h0, run ? {16'h0, pre[2'(i)]} : 32'h0);
      wb(1'b0, SDIO_OFS_STATUS, 32'h0, {22'h0, 2'(i), 2'h0, run, 1'b0, 2'(i), run, 1'b1});
    end
    wb(1'b1, SDIO_OFS_CONFIG, 32'h0000_0200, 32'h0);
    pin_cmd <= 4'h3;
    repeat (30) @(posedge sys_clk);
    chk({drive_enable, motor_run}, 2'b10);
    pin_cmd <= 4'h0;
    repeat (30) @(posedge sys_clk);
    chk(drive_enable, 1'b0);
    wb(1'b1, SDIO_OFS_ZSPEED, 32'h0000_0100, 32'h0);
    for (int k = 0; k < 48; k++) begin
      s = 3'(k);
      wb(1'b1, SDIO_OFS_CONFIG, {29'h0, s}, 32'h0);
      {fan_warning, overload_warning, regen_warning, torque_limited} <= 4'($random(seed));
      motor_speed <= 16'h00fe + 16'({$random(seed)} % 5);
      regen_load <= 16'h0350 + 16'({$random(seed)} % 5);
      effective_torque <= 16'h01fe + 16'({$random(seed)} % 5);
      repeat (2) @(posedge sys_clk);
      chk(warning_out, warn_exp(s));
    end
    torque_limited <= 1'b0;
    wb(1'b1, SDIO_OFS_CONFIG, 32'h0, 32'h0);
    wb(1'b1, SDIO_OFS_IRQ_ST, 32'h0000_000f, 32'h0);
    wb(1'b0, SDIO_OFS_IRQ_ST, 32'h0, 32'h0);
    wb(1'b1, SDIO_OFS_IRQ_MSK, 32'h0000_0001, 32'h0);
    torque_limited <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk(irq, 1'b1);
    wb(1'b1, SDIO_OFS_IRQ_MSK, 32'h0, 32'h0);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    wb(1'b1, SDIO_OFS_IRQ_MSK, 32'h0000_0001, 32'h0);
    wb(1'b1, SDIO_OFS_IRQ_ST, 32'h0000_0001, 32'h0);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    for (int k = 0; k < 32; k++) begin
      if (k == 16) wb(1'b1, SDIO_OFS_CONFIG, 32'h0000_0010, 32'h0);
      enc <= 3'($random(seed));
      repeat (2) @(posedge sys_clk);
      chk({enc_out_z_pos, enc_out_b_pos, enc_out_a_pos}, enc ^ {1'b0, k >= 16, 1'b0});
      chk({index_open_collector_out, index_open_collector_oe}, {1'b0, enc[2]});
    end
    test_done();
  end
  // the whole run needs about 750 cycles; allow over twenty times that
  initial begin
    #100000;
    miscompares++;
    test_done();
  end
endmodule // tb_top
